// File: hw/pcrs_top.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module pcrs_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic step_req,
    input wire logic jump_req,
    input wire logic call_req,
    input wire logic intr_req,
    input wire logic ret_req,
    input wire logic [14:0] target_addr,
    output logic [14:0] pc,
    output logic [12:0] fetch_addr,
    output logic stack_reset_req,
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [14:0] next_pc;
    logic [6:0] pc_upper_latch;
    logic [6:0] next_pc_upper_latch;
    logic [4:0] stack_pointer_reg;
    logic [4:0] next_stack_pointer_reg;
    logic [1:0] flags;
    logic [1:0] next_flags;
    logic [1:0] mask;
    logic [1:0] next_mask;
    logic stack_wrap_reset_enable;
    logic next_stack_wrap_reset_enable;
    logic next_stack_reset_req;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [14:0] wr_data;
    logic [14:0] tos;
    logic do_push;
    logic do_pop;
    logic ovf;
    logic unf;
    logic acc;
    logic wr;
    logic [9:0] idx;

    // Word index of the access compared against one register's index
    function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
        return a == r;
    endfunction

    function automatic logic known(input logic [9:0] a);
        return hit(a, pcrs_pkg::IDX_PC_LOW) || hit(a, pcrs_pkg::IDX_PC_LATCH)
            || hit(a, pcrs_pkg::IDX_STACK_PTR)
            || hit(a, pcrs_pkg::IDX_TOS_LOW)
            || hit(a, pcrs_pkg::IDX_TOS_HIGH)
            || hit(a, pcrs_pkg::IDX_STATUS) || hit(a, pcrs_pkg::IDX_MASK)
            || hit(a, pcrs_pkg::IDX_CONFIG);
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Zero wait states, so the access phase always completes at once
    assign pready = 1'b1;
    assign acc = psel && penable && ce;
    assign wr = acc && pwrite && known(idx);
    assign idx = paddr[11:2];

    // Interrupt has priority over call, call over return
    assign do_push = intr_req || call_req;
    assign do_pop = ret_req && !do_push;
    assign ovf = do_push && (stack_pointer_reg == pcrs_pkg::SP_TOP);
    assign unf = do_pop && (stack_pointer_reg == pcrs_pkg::SP_EMPTY);

    // ------------------------------------------------------------
    // Stack storage
    // ------------------------------------------------------------
    pcrs_stack_mem #(
        .DEPTH(pcrs_pkg::DEPTH),
        .WIDTH(pcrs_pkg::PC_W),
        .IDX_W(4)
    ) u_stack (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_idx(stack_pointer_reg[3:0]),
        .rd_data(tos)
    );

    // ------------------------------------------------------------
    // Program counter, pointer and stack write
    // ------------------------------------------------------------
    // Core operations win over a software write in the same cycle
    always_comb
    begin
        next_pc = pc;
        next_stack_pointer_reg = stack_pointer_reg;
        next_stack_reset_req = 1'b0;
        wr_en = 1'b0;
        wr_idx = stack_pointer_reg[3:0];
        wr_data = tos;
        if (do_push)
        begin
            if (ovf && stack_wrap_reset_enable)
            begin
                next_stack_reset_req = 1'b1;
            end
            else
            begin
                // Pointer first, then the entry it now names
                next_stack_pointer_reg = stack_pointer_reg + 5'h01;
                if (ovf)
                begin
                    next_stack_pointer_reg = 5'h00;
                end
                wr_en = 1'b1;
                wr_idx = next_stack_pointer_reg[3:0];
                wr_data = pc;
            end
            next_pc = intr_req ? pcrs_pkg::INTR_VECTOR : target_addr;
        end
        else if (do_pop)
        begin
            if (unf && stack_wrap_reset_enable)
            begin
                next_stack_reset_req = 1'b1;
            end
            else
            begin
                next_pc = tos;
                next_stack_pointer_reg = unf ? pcrs_pkg::SP_AFTER_UNF
                    : stack_pointer_reg - 5'h01;
            end
        end
        else if (jump_req)
        begin
            next_pc = target_addr;
        end
        else if (step_req)
        begin
            next_pc = pc + 15'h0001;
        end
        else if (wr && hit(idx, pcrs_pkg::IDX_PC_LOW))
        begin
            next_pc = {pc_upper_latch, pwdata[7:0]};
        end
        else if (wr && hit(idx, pcrs_pkg::IDX_STACK_PTR))
        begin
            // An interrupt push here would win
            next_stack_pointer_reg = pwdata[4:0];
        end
        else if (wr && hit(idx, pcrs_pkg::IDX_TOS_LOW))
        begin
            wr_en = 1'b1;
            wr_data = {tos[14:8], pwdata[7:0]};
        end
        else if (wr && hit(idx, pcrs_pkg::IDX_TOS_HIGH))
        begin
            wr_en = 1'b1;
            wr_data = {pwdata[6:0], tos[7:0]};
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pc <= pcrs_pkg::RESET_VECTOR;
            stack_pointer_reg <= pcrs_pkg::SP_RESET;
            stack_reset_req <= 1'b0;
        end
        else if (ce)
        begin
            pc <= next_pc;
            stack_pointer_reg <= next_stack_pointer_reg;
            stack_reset_req <= next_stack_reset_req;
        end
    end

    // Upper bits above 8K are ignored, so fetches wrap without fault
    assign fetch_addr = pc[12:0];

    // ------------------------------------------------------------
    // Software registers and sticky flags
    // ------------------------------------------------------------
    // Set beats write-one-to-clear in the same cycle
    always_comb
    begin
        next_pc_upper_latch = pc_upper_latch;
        next_mask = mask;
        next_stack_wrap_reset_enable = stack_wrap_reset_enable;
        next_flags = flags;
        if (wr && hit(idx, pcrs_pkg::IDX_PC_LATCH))
        begin
            next_pc_upper_latch = pwdata[6:0];
        end
        if (wr && hit(idx, pcrs_pkg::IDX_MASK))
        begin
            next_mask = pwdata[1:0];
        end
        if (wr && hit(idx, pcrs_pkg::IDX_CONFIG))
        begin
            next_stack_wrap_reset_enable = pwdata[pcrs_pkg::CFG_WRAP_RST];
        end
        if (wr && hit(idx, pcrs_pkg::IDX_STATUS))
        begin
            next_flags = flags & ~pwdata[1:0];
        end
        next_flags[pcrs_pkg::FLAG_OVF] = next_flags[pcrs_pkg::FLAG_OVF] | ovf;
        next_flags[pcrs_pkg::FLAG_UNF] = next_flags[pcrs_pkg::FLAG_UNF] | unf;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pc_upper_latch <= pcrs_pkg::LATCH_RESET;
            mask <= pcrs_pkg::FLAGS_RESET;
            stack_wrap_reset_enable <= 1'b0;
            flags <= pcrs_pkg::FLAGS_RESET;
        end
        else if (ce)
        begin
            pc_upper_latch <= next_pc_upper_latch;
            mask <= next_mask;
            stack_wrap_reset_enable <= next_stack_wrap_reset_enable;
            flags <= next_flags;
        end
    end

    assign irq = |(flags & mask);

    // ------------------------------------------------------------
    // Read data and error answer
    // ------------------------------------------------------------
    // Registered read data; the value of the pre-access cycle is shown
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (idx)
            pcrs_pkg::IDX_PC_LOW: next_prdata[7:0] = pc[7:0];
            pcrs_pkg::IDX_PC_LATCH: next_prdata[6:0] = pc_upper_latch;
            pcrs_pkg::IDX_STACK_PTR: next_prdata[4:0] = stack_pointer_reg;
            pcrs_pkg::IDX_TOS_LOW: next_prdata[7:0] = tos[7:0];
            pcrs_pkg::IDX_TOS_HIGH: next_prdata[6:0] = tos[14:8];
            pcrs_pkg::IDX_STATUS: next_prdata[1:0] = flags;
            pcrs_pkg::IDX_MASK: next_prdata[1:0] = mask;
            pcrs_pkg::IDX_CONFIG: next_prdata[0] = stack_wrap_reset_enable;
            default: next_pslverr = 1'b1;
        endcase
        if (!(psel && !penable))
        begin
            next_prdata = prdata;
            next_pslverr = pslverr;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_push_mid;
        ce && do_push && !intr_req && !ovf;
    endsequence

    property p_push_sp;
        @(posedge ref_clk) disable iff (rst)
        s_push_mid |=> stack_pointer_reg == $past(stack_pointer_reg) + 5'h01;
    endproperty
    a_push_sp: assert property (p_push_sp) else $error("push pointer");

    property p_push_data;
        @(posedge ref_clk) disable iff (rst)
        ce && do_push && !(ovf && stack_wrap_reset_enable)
            |=> tos == $past(pc);
    endproperty
    a_push_data: assert property (p_push_data) else $error("push data");

    property p_intr_vec;
        @(posedge ref_clk) disable iff (rst)
        ce && intr_req |=> pc == pcrs_pkg::INTR_VECTOR;
    endproperty
    a_intr_vec: assert property (p_intr_vec) else $error("intr vector");

    property p_pop_pc;
        @(posedge ref_clk) disable iff (rst)
        ce && do_pop && !unf |=> pc == $past(tos)
            && stack_pointer_reg == $past(stack_pointer_reg) - 5'h01;
    endproperty
    a_pop_pc: assert property (p_pop_pc) else $error("pop");

    property p_latch_kept;
        @(posedge ref_clk) disable iff (rst)
        ce && (do_push || do_pop) && !wr |=> $stable(pc_upper_latch);
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("latch");

    property p_wrap;
        @(posedge ref_clk) disable iff (rst)
        ce && ovf && !stack_wrap_reset_enable
            |=> stack_pointer_reg == 5'h00 && flags[pcrs_pkg::FLAG_OVF];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap");

    property p_unf_flag;
        @(posedge ref_clk) disable iff (rst)
        ce && unf |=> flags[pcrs_pkg::FLAG_UNF]
            && (irq || !mask[pcrs_pkg::FLAG_UNF]);
    endproperty
    a_unf_flag: assert property (p_unf_flag) else $error("underflow");

    property p_reset_req;
        @(posedge ref_clk) disable iff (rst)
        ce && (ovf || unf) && stack_wrap_reset_enable
            |=> stack_reset_req && $stable(stack_pointer_reg);
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("reset req");

    property p_step;
        @(posedge ref_clk) disable iff (rst)
        ce && step_req && !jump_req && !do_push && !ret_req
            |=> pc == $past(pc) + 15'h0001 && fetch_addr == pc[12:0];
    endproperty
    a_step: assert property (p_step) else $error("step");

endmodule

// File: hw/pcrs_pkg.sv
package pcrs_pkg;

    // ------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_PC_LOW = 10'h102;
    localparam logic [9:0] IDX_PC_LATCH = 10'h10a;
    localparam logic [9:0] IDX_STACK_PTR = 10'h120;
    localparam logic [9:0] IDX_TOS_LOW = 10'h121;
    localparam logic [9:0] IDX_TOS_HIGH = 10'h122;
    localparam logic [9:0] IDX_STATUS = 10'h123;
    localparam logic [9:0] IDX_MASK = 10'h124;
    localparam logic [9:0] IDX_CONFIG = 10'h125;

    // ------------------------------------------------------------
    // Widths, vectors and reset values
    // ------------------------------------------------------------
    localparam int PC_W = 15;
    localparam int FETCH_W = 13;
    localparam int SP_W = 5;
    localparam int DEPTH = 16;
    localparam logic [14:0] RESET_VECTOR = 15'h0000;
    localparam logic [14:0] INTR_VECTOR = 15'h0004;
    localparam logic [6:0] LATCH_RESET = 7'h00;
    localparam logic [4:0] SP_RESET = 5'h1f;
    localparam logic [4:0] SP_TOP = 5'h0f;
    localparam logic [4:0] SP_EMPTY = 5'h1f;
    localparam logic [4:0] SP_AFTER_UNF = 5'h0e;
    localparam logic [1:0] FLAGS_RESET = 2'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FLAG_OVF = 0;
    localparam int FLAG_UNF = 1;
    localparam int CFG_WRAP_RST = 0;

endpackage

// File: hw/pcrs_stack_mem.sv
`timescale 1ns/1ns
// Flip-flop return stack, one write port and one read port
module pcrs_stack_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 15,
    parameter int IDX_W = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];

    // ------------------------------------------------------------
    // Storage apart from program and data space
    // ------------------------------------------------------------
    always_comb
    begin
        next_mem = mem;
        if (wr_en)
        begin
            next_mem[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= '0;
            end
        end
        else if (ce)
        begin
            mem <= next_mem;
        end
    end

    // Combinational read so top of stack follows the pointer at once
    assign rd_data = mem[rd_idx];

endmodule

// File: dv/pcrs_seq_model.sv
`timescale 1ns/1ns
// Instruction sequencer stand-in: one request at a time, one cycle wide
module pcrs_seq_model (
    input wire logic ref_clk,
    input wire logic sw_busy,
    output logic step_req,
    output logic jump_req,
    output logic call_req,
    output logic intr_req,
    output logic ret_req,
    output logic [14:0] target_addr
);
    // ------------------------------------------------------------
    // Idle state at time zero
    // ------------------------------------------------------------
    initial
    begin
        {step_req, jump_req, call_req, intr_req, ret_req} = 5'h00;
        target_addr = 15'h0000;
    end

    // ------------------------------------------------------------
    // Request issue: 0 step, 1 jump, 2 call, 3 intr, 4 return
    // ------------------------------------------------------------
    task automatic issue(input logic [2:0] kind, input logic [14:0] tgt);
        @(posedge ref_clk);
        // Never push while software is moving the pointer
        while (sw_busy)
        begin
            @(posedge ref_clk);
        end
        target_addr <= tgt;
        step_req <= (kind == 3'h0);
        jump_req <= (kind == 3'h1);
        call_req <= (kind == 3'h2);
        intr_req <= (kind == 3'h3);
        ret_req <= (kind == 3'h4);
        @(posedge ref_clk);
        {step_req, jump_req, call_req, intr_req, ret_req} <= 5'h00;
        // Target not held past the request, so stale use shows up
        target_addr <= ~tgt;
        #1;
    endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam logic [9:0] A_LOW = pcrs_pkg::IDX_PC_LOW;
    localparam logic [9:0] A_LAT = pcrs_pkg::IDX_PC_LATCH;
    localparam logic [9:0] A_SP = pcrs_pkg::IDX_STACK_PTR;
    localparam logic [9:0] A_TL = pcrs_pkg::IDX_TOS_LOW;
    localparam logic [9:0] A_TH = pcrs_pkg::IDX_TOS_HIGH;
    localparam logic [9:0] A_ST = pcrs_pkg::IDX_STATUS;
    localparam logic [9:0] A_MSK = pcrs_pkg::IDX_MASK;
    localparam logic [9:0] A_CFG = pcrs_pkg::IDX_CONFIG;
    localparam logic [2:0] STEP = 3'h0;
    localparam logic [2:0] JUMP = 3'h1;
    localparam logic [2:0] CALL = 3'h2;
    localparam logic [2:0] INTR = 3'h3;
    localparam logic [2:0] RET = 3'h4;
    logic ref_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic step_req, jump_req, call_req, intr_req, ret_req, rerr;
    logic [14:0] target_addr, pc;
    logic [12:0] fetch_addr;
    logic stack_reset_req, irq;
    int n_errors;
    int n_compared;

    pcrs_top uut (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .step_req(step_req), .jump_req(jump_req),
        .call_req(call_req), .intr_req(intr_req), .ret_req(ret_req),
        .target_addr(target_addr), .pc(pc), .fetch_addr(fetch_addr),
        .stack_reset_req(stack_reset_req), .irq(irq)
    );

    pcrs_seq_model seq (
        .ref_clk(ref_clk), .sw_busy(psel), .step_req(step_req),
        .jump_req(jump_req), .call_req(call_req), .intr_req(intr_req),
        .ret_req(ret_req), .target_addr(target_addr)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h",
                $time, seen, exp);
        end
    endtask

    // APB transfer; waits on pready as long as the slave takes
    task automatic apb(input logic wr, input logic [9:0] idx,
        input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // Only the watchdog ends a wait on a dead slave
        while (pready !== 1'b1)
        begin
            @(posedge ref_clk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        check(rdata, exp);
    endtask

    task automatic op(input logic [2:0] kind, input logic [14:0] tgt);
        seq.issue(kind, tgt);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Tests need well under 2000 cycles
    initial
    begin
        #400000;
        n_errors++;
        summarize();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        n_errors = 0;
        n_compared = 0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check(32'(pc), 32'h0000_0000);
        rdc(A_SP, 32'h0000_001f);
        rdc(A_LOW, 32'h0000_0000);
        rdc(A_LAT, 32'h0000_0000);
        rdc(A_ST, 32'h0000_0000);
        check(32'(pready), 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        done("reset");
        op(JUMP, 15'h7fff);
        check(32'(pc), 32'h0000_7fff);
        check(32'(fetch_addr), 32'h0000_1fff);
        op(STEP, 15'h0000);
        check(32'(pc), 32'h0000_0000);
        op(JUMP, 15'h2005);
        check(32'(fetch_addr), 32'h0000_0005);
        @(posedge ref_clk);
        ce <= 1'b0;
        op(STEP, 15'h0000);
        check(32'(pc), 32'h0000_2005);
        @(posedge ref_clk);
        ce <= 1'b1;
        wr(A_LAT, 32'h0000_00d5);
        rdc(A_LAT, 32'h0000_0055);
        wr(A_LOW, 32'h0000_0034);
        check(32'(pc), 32'h0000_5534);
        done("counter");
        // Seventeen calls: the last one wraps onto entry zero
        for (int i = 0; i < 17; i++)
        begin
            op(JUMP, 15'(32'h1000 + i));
            op(CALL, 15'(32'h2000 + i));
            check(32'(pc), 32'h2000 + i);
            rdc(A_SP, 32'(i % 16));
            rdc(A_TL, 32'(i));
            rdc(A_TH, 32'h0000_0010);
        end
        rdc(A_ST, 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        rdc(A_LAT, 32'h0000_0055);
        wr(A_SP, 32'h0000_0001);
        rdc(A_TL, 32'h0000_0001);
        wr(A_SP, 32'h0000_0000);
        op(RET, 15'h0000);
        check(32'(pc), 32'h0000_1010);
        rdc(A_SP, 32'h0000_001f);
        op(RET, 15'h0000);
        check(32'(pc), 32'h0000_100f);
        rdc(A_SP, 32'h0000_000e);
        rdc(A_ST, 32'h0000_0003);
        rdc(A_LAT, 32'h0000_0055);
        done("stack");
        wr(A_MSK, 32'h0000_0003);
        check(32'(irq), 32'h0000_0001);
        wr(A_ST, 32'h0000_0001);
        rdc(A_ST, 32'h0000_0002);
        check(32'(irq), 32'h0000_0001);
        wr(A_ST, 32'h0000_0002);
        check(32'(irq), 32'h0000_0000);
        done("interrupt flags");
        op(JUMP, 15'h0123);
        op(INTR, 15'h0000);
        check(32'(pc), 32'h0000_0004);
        rdc(A_SP, 32'h0000_000f);
        rdc(A_TL, 32'h0000_0023);
        op(RET, 15'h0000);
        check(32'(pc), 32'h0000_0123);
        wr(A_SP, 32'h0000_0005);
        wr(A_TL, 32'h0000_00ab);
        wr(A_TH, 32'h0000_0012);
        rdc(A_TL, 32'h0000_00ab);
        rdc(A_TH, 32'h0000_0012);
        op(RET, 15'h0000);
        check(32'(pc), 32'h0000_12ab);
        rdc(A_SP, 32'h0000_0004);
        done("vector and access");
        wr(A_CFG, 32'h0000_0001);
        wr(A_SP, 32'h0000_000f);
        op(CALL, 15'h0777);
        check(32'(stack_reset_req), 32'h0000_0001);
        check(32'(pc), 32'h0000_0777);
        rdc(A_SP, 32'h0000_000f);
        check(32'(stack_reset_req), 32'h0000_0000);
        wr(A_SP, 32'h0000_001f);
        op(RET, 15'h0000);
        check(32'(stack_reset_req), 32'h0000_0001);
        check(32'(pc), 32'h0000_0777);
        rdc(A_ST, 32'h0000_0003);
        apb(1'b0, 10'h3ff, 32'h0000_0000);
        check(32'(rerr), 32'h0000_0001);
        check(rdata, 32'h0000_0000);
        done("wrap reset and unmapped");
        summarize();
    end
endmodule
